// *** include/adc_ctrl_pkg.sv ***
// Purpose: shared constants of the converter control port
// Assumes: 16-bit control frames, 20 MHz core clock
// Notes: register offsets are 7-bit addresses carried in frame bits 14:8
`default_nettype none
package adc_ctrl_pkg;
    // =====================================================
    // frame layout
    localparam logic [4:0] FRAME_LAST = 5'h10;
    localparam logic [4:0] CNT_SAT = 5'h1f;
    localparam int RW_BIT = 15;
    localparam logic [15:0] ERR_RESP = 16'h0e00;
    // =====================================================
    // register offsets
    localparam logic [6:0] A_STANDBY = 7'h00;
    localparam logic [6:0] A_PROF_A = 7'h01;
    localparam logic [6:0] A_PROF_B = 7'h02;
    localparam logic [6:0] A_PROF_SEL = 7'h03;
    localparam logic [6:0] A_POWER = 7'h04;
    localparam logic [6:0] A_SYNC = 7'h06;
    localparam logic [6:0] A_IFACE = 7'h07;
    localparam logic [6:0] A_STATUS = 7'h09;
    // =====================================================
    // reset values and fields
    localparam logic [7:0] STANDBY_RST = 8'h00;
    localparam logic [7:0] PROF_RST = 8'h0d; // sinc5, x1024
    localparam logic [7:0] SEL_RST = 8'h00;
    localparam logic [7:0] POWER_RST = 8'h00; // low power, mclk/32
    localparam logic [7:0] IFACE_RST = 8'h13; // header on, crc off, data_clock_out /8
    localparam logic SYNC_RST = 1'b1;
    localparam logic [6:0] PIN_RST = 7'h02; // chip select idles high
    localparam int SYNC_BIT = 7;
    localparam logic [2:0] DEC_MAX = 3'h5;
    localparam logic [10:0] DEC_BASE = 11'h020;
    localparam logic [1:0] SRST_FIRST = 2'h3;
    localparam logic [1:0] SRST_SECOND = 2'h2;
    localparam int REPEAT_BIT = 0;
    // =====================================================
    // timing
    localparam int CLK_NS = 50;
    localparam int STARTUP_NS = 100000;
    localparam int BOOT_CYC = (STARTUP_NS + CLK_NS - 1) / CLK_NS;
    localparam logic [11:0] BOOT_CNT = 12'(BOOT_CYC);
endpackage
`default_nettype wire

// *** hdl/adc_ctrl_port.sv ***
// Purpose: control port, channel standby and profile data path of the converter
// Assumes: host clocks the control port far slower than CORE_CLK
// Notes: profile settings take effect only at a sync event or a software reset
// Functional notes
// - standby pins idle channel banks per table
// - idle channel keeps slot, zero header/result
// - channel 0 idle disables common-mode output
// - channel 4 idle disables crystal drive
// - mode 0: sample rising, shift falling
// - register control only with select high
// - 16-bit frame, bit15 read, bits14:8 address
// - answer appears in the following frame
// - write answer: zero byte then data
// - illegal command answers 0x0e00
// - accesses ignored during start-up time
// - power and interface defaults after reset
// - profiles sinc5 x1024, selection 0x00
// - all channels enabled after reset
// - sync bit 0 then 1 pulses sync
// - standby register at 0x00 per channel
// - set standby bit idles that channel
// - two profiles, per-channel select register
// - profile bit3 filter, bits2:0 decimation
// - ready at fastest rate, stale flagged
// - all channels profile B: no data
// - two commands trigger full software reset
// - first answer after soft reset 0x0e00
`default_nettype none
module adc_ctrl_port (
    input wire logic CORE_CLK,
    input wire logic RESETN,
    input wire logic CLK_EN,
    input wire logic SPI_SELECT_PIN,
    input wire logic BANK_LOW_STANDBY_PIN,
    input wire logic BANK_HIGH_STANDBY_PIN,
    input wire logic SPI_SCLK,
    input wire logic SPI_CS_N,
    input wire logic SPI_SDI,
    input wire logic SYNC_IN_PIN,
    input wire logic MOD_TICK,
    input wire logic [63:0] RAW_HEADER,
    input wire logic [127:0] RAW_RESULT,
    output logic SPI_SDO,
    output logic SPI_SDO_OE,
    output logic SYNC_OUT,
    output logic [7:0] CHANNEL_ENABLE,
    output logic COMMON_MODE_VOLTAGE_OUT,
    output logic CRYSTAL_EXCITE_EN,
    output logic [7:0] POWER_CFG,
    output logic [7:0] IFACE_CFG,
    output logic DATA_READY_STROBE,
    output logic [63:0] OUT_HEADER,
    output logic [127:0] OUT_RESULT
);
    import adc_ctrl_pkg::*;

    // last sample of a clamped decimation code, ratio minus one
    function automatic logic [9:0] dec_last(input logic [2:0] code);
        logic [2:0] c;
        logic [10:0] r;
        c = (code > DEC_MAX) ? DEC_MAX : code;
        r = DEC_BASE << c;
        return 10'(r - 11'h001);
    endfunction

    // =====================================================
    // input synchronisers
    logic [6:0] meta_ff;
    logic [6:0] pin_ff;
    logic [2:0] last_ff;

    // two flops per pin; edges compare the second stage with a third flop
    always_ff @(posedge CORE_CLK) begin
        if (!RESETN) begin
            meta_ff <= PIN_RST;
            pin_ff <= PIN_RST;
            last_ff <= 3'h2;
        end else if (CLK_EN) begin
            meta_ff <= {SPI_SELECT_PIN, BANK_HIGH_STANDBY_PIN, BANK_LOW_STANDBY_PIN,
                        SYNC_IN_PIN, SPI_SDI, SPI_CS_N, SPI_SCLK};
            pin_ff <= meta_ff;
            last_ff <= {pin_ff[3], pin_ff[1], pin_ff[0]};
        end
    end

    logic sclk_rise;
    logic sclk_fall;
    logic cs_low;
    logic cs_fall;
    logic cs_rise;
    logic syncin_rise;
    logic spi_mode;

    // edge decode on the synchronised copies
    assign sclk_rise = pin_ff[0] & ~last_ff[0];
    assign sclk_fall = ~pin_ff[0] & last_ff[0];
    assign cs_low = ~pin_ff[1];
    assign cs_fall = ~pin_ff[1] & last_ff[1];
    assign cs_rise = pin_ff[1] & ~last_ff[1];
    assign syncin_rise = pin_ff[3] & ~last_ff[2];
    assign spi_mode = pin_ff[6];

    // =====================================================
    // control port and register file
    logic [15:0] shift_ff, nxt_shift;
    logic [15:0] tx_ff, nxt_tx;
    logic [15:0] resp_ff, nxt_resp;
    logic [4:0] bit_cnt_ff, nxt_bit_cnt;
    logic [11:0] boot_ff, nxt_boot;
    logic [7:0] standby_ff, nxt_standby;
    logic [7:0] prof_a_ff, nxt_prof_a;
    logic [7:0] prof_b_ff, nxt_prof_b;
    logic [7:0] sel_ff, nxt_sel;
    logic [7:0] power_ff, nxt_power;
    logic [7:0] iface_ff, nxt_iface;
    logic sync_bit_ff, nxt_sync_bit;
    logic armed_ff, nxt_armed;
    logic pending_ff, nxt_pending;
    logic [7:0] act_a_ff, nxt_act_a;
    logic [7:0] act_b_ff, nxt_act_b;
    logic [7:0] act_sel_ff, nxt_act_sel;
    logic [7:0] en_ff, nxt_en;
    logic exec;
    logic illegal;
    logic sync_evt;
    logic srst;

    // frame shifting, command execution and sync application
    always_comb begin
        logic rd;
        logic bad;
        logic ro;
        logic spi_sync;
        logic cfg_wr;
        logic [6:0] addr;
        logic [7:0] wd;
        logic [7:0] rdata;
        rdata = 8'h00;
        rd = shift_ff[RW_BIT];
        addr = shift_ff[14:8];
        wd = shift_ff[7:0];
        bad = 1'b0;
        ro = 1'b0;
        spi_sync = 1'b0;
        cfg_wr = 1'b0;
        srst = 1'b0;
        nxt_shift = shift_ff;
        nxt_tx = tx_ff;
        nxt_resp = resp_ff;
        nxt_bit_cnt = bit_cnt_ff;
        nxt_boot = boot_ff;
        nxt_standby = standby_ff;
        nxt_prof_a = prof_a_ff;
        nxt_prof_b = prof_b_ff;
        nxt_sel = sel_ff;
        nxt_power = power_ff;
        nxt_iface = iface_ff;
        nxt_sync_bit = sync_bit_ff;
        nxt_armed = armed_ff;
        nxt_pending = pending_ff;
        nxt_act_a = act_a_ff;
        nxt_act_b = act_b_ff;
        nxt_act_sel = act_sel_ff;
        unique case (addr)
            A_STANDBY: rdata = standby_ff;
            A_PROF_A: rdata = prof_a_ff;
            A_PROF_B: rdata = prof_b_ff;
            A_PROF_SEL: rdata = sel_ff;
            A_POWER: rdata = power_ff;
            A_SYNC: rdata = {sync_bit_ff, 7'h00};
            A_IFACE: rdata = iface_ff;
            A_STATUS: begin
                rdata = {7'h00, pending_ff};
                ro = 1'b1;
            end
            default: begin
                rdata = 8'h00;
                bad = 1'b1;
            end
        endcase
        illegal = bad | (ro & ~rd);
        // start-up window swallows whole frames
        exec = spi_mode && cs_rise && (bit_cnt_ff == FRAME_LAST) && (boot_ff == 12'h000);
        if (boot_ff != 12'h000) begin
            nxt_boot = boot_ff - 12'h001;
        end
        if (cs_fall) begin
            nxt_bit_cnt = 5'h00;
            nxt_tx = resp_ff;
        end else if (cs_low) begin
            if (sclk_rise) begin
                nxt_shift = {shift_ff[14:0], pin_ff[2]};
                if (bit_cnt_ff != CNT_SAT) begin
                    nxt_bit_cnt = bit_cnt_ff + 5'h01;
                end
            end
            if (sclk_fall) begin
                nxt_tx = {tx_ff[14:0], 1'b0};
            end
        end
        if (exec) begin
            nxt_armed = 1'b0;
            if (illegal) begin
                nxt_resp = ERR_RESP;
            end else if (rd) begin
                nxt_resp = {shift_ff[15:8], rdata};
            end else begin
                nxt_resp = {8'h00, wd};
                unique case (addr)
                    A_STANDBY: nxt_standby = wd;
                    A_PROF_A: nxt_prof_a = wd;
                    A_PROF_B: nxt_prof_b = wd;
                    A_PROF_SEL: nxt_sel = wd;
                    A_POWER: nxt_power = wd;
                    A_IFACE: nxt_iface = wd;
                    default: begin
                        nxt_sync_bit = wd[SYNC_BIT];
                        spi_sync = wd[SYNC_BIT] & ~sync_bit_ff;
                        nxt_armed = (wd[1:0] == SRST_FIRST);
                        srst = armed_ff && (wd[1:0] == SRST_SECOND);
                    end
                endcase
                cfg_wr = (addr == A_PROF_A) || (addr == A_PROF_B) || (addr == A_PROF_SEL);
            end
        end
        sync_evt = spi_sync | syncin_rise;
        // profiles reach the data path only at a sync or a software reset
        if (sync_evt) begin
            nxt_act_a = prof_a_ff;
            nxt_act_b = prof_b_ff;
            nxt_act_sel = sel_ff;
            nxt_pending = 1'b0;
        end
        if (cfg_wr) begin
            nxt_pending = 1'b1;
        end
        // software reset restores the register defaults and active profiles and restarts the quiet window
        if (srst) begin
            nxt_standby = STANDBY_RST;
            nxt_prof_a = PROF_RST;
            nxt_prof_b = PROF_RST;
            nxt_sel = SEL_RST;
            nxt_power = POWER_RST;
            nxt_iface = IFACE_RST;
            nxt_sync_bit = SYNC_RST;
            nxt_act_a = PROF_RST;
            nxt_act_b = PROF_RST;
            nxt_act_sel = SEL_RST;
            nxt_pending = 1'b0;
            nxt_resp = ERR_RESP;
            nxt_boot = BOOT_CNT;
        end
        // pins rule the banks outside register control
        nxt_en = ~(spi_mode ? standby_ff : {{4{pin_ff[5]}}, {4{pin_ff[4]}}});
    end

    // register stage of the control port
    always_ff @(posedge CORE_CLK) begin
        if (!RESETN) begin
            shift_ff <= 16'h0000;
            tx_ff <= 16'h0000;
            resp_ff <= 16'h0000;
            bit_cnt_ff <= 5'h00;
            boot_ff <= BOOT_CNT;
            standby_ff <= STANDBY_RST;
            prof_a_ff <= PROF_RST;
            prof_b_ff <= PROF_RST;
            sel_ff <= SEL_RST;
            power_ff <= POWER_RST;
            iface_ff <= IFACE_RST;
            sync_bit_ff <= SYNC_RST;
            armed_ff <= 1'b0;
            pending_ff <= 1'b0;
            act_a_ff <= PROF_RST;
            act_b_ff <= PROF_RST;
            act_sel_ff <= SEL_RST;
            en_ff <= 8'hff;
        end else if (CLK_EN) begin
            shift_ff <= nxt_shift;
            tx_ff <= nxt_tx;
            resp_ff <= nxt_resp;
            bit_cnt_ff <= nxt_bit_cnt;
            boot_ff <= nxt_boot;
            standby_ff <= nxt_standby;
            prof_a_ff <= nxt_prof_a;
            prof_b_ff <= nxt_prof_b;
            sel_ff <= nxt_sel;
            power_ff <= nxt_power;
            iface_ff <= nxt_iface;
            sync_bit_ff <= nxt_sync_bit;
            armed_ff <= nxt_armed;
            pending_ff <= nxt_pending;
            act_a_ff <= nxt_act_a;
            act_b_ff <= nxt_act_b;
            act_sel_ff <= nxt_act_sel;
            en_ff <= nxt_en;
        end
    end

    // =====================================================
    // profile rate counters and output slots
    logic [9:0] cnt_a_ff, nxt_cnt_a;
    logic [9:0] cnt_b_ff, nxt_cnt_b;
    logic data_ready_strobe_ff, nxt_data_ready_strobe;
    logic [63:0] hdr_ff, nxt_hdr;
    logic [127:0] res_ff, nxt_res;

    // ready follows the faster profile in use; profile a is the primary group
    always_comb begin
        logic [9:0] last_a;
        logic [9:0] last_b;
        logic wrap_a;
        logic wrap_b;
        logic used_a;
        logic used_b;
        logic fresh;
        fresh = 1'b0;
        last_a = dec_last(act_a_ff[2:0]);
        last_b = dec_last(act_b_ff[2:0]);
        wrap_a = MOD_TICK && (cnt_a_ff == last_a);
        wrap_b = MOD_TICK && (cnt_b_ff == last_b);
        used_a = |(~act_sel_ff);
        used_b = |act_sel_ff;
        nxt_cnt_a = cnt_a_ff;
        nxt_cnt_b = cnt_b_ff;
        if (sync_evt) begin
            nxt_cnt_a = 10'h000;
            nxt_cnt_b = 10'h000;
        end else if (MOD_TICK) begin
            nxt_cnt_a = wrap_a ? 10'h000 : cnt_a_ff + 10'h001;
            nxt_cnt_b = wrap_b ? 10'h000 : cnt_b_ff + 10'h001;
        end
        nxt_data_ready_strobe = !sync_evt && used_a &&
                   ((!used_b || last_a <= last_b) ? wrap_a : wrap_b);
        nxt_hdr = hdr_ff;
        nxt_res = res_ff;
        if (nxt_data_ready_strobe) begin
            for (int i = 0; i < 8; i++) begin
                fresh = act_sel_ff[i] ? wrap_b : wrap_a;
                if (!en_ff[i]) begin
                    nxt_hdr[i*8 +: 8] = 8'h00;
                    nxt_res[i*16 +: 16] = 16'h0000;
                end else if (fresh) begin
                    nxt_hdr[i*8 +: 8] = RAW_HEADER[i*8 +: 8];
                    nxt_res[i*16 +: 16] = RAW_RESULT[i*16 +: 16];
                end else begin
                    nxt_hdr[i*8 +: 8] = RAW_HEADER[i*8 +: 8] | (8'h01 << REPEAT_BIT);
                    nxt_res[i*16 +: 16] = 16'h0000;
                end
            end
        end
    end

    // register stage of the data path
    always_ff @(posedge CORE_CLK) begin
        if (!RESETN) begin
            cnt_a_ff <= 10'h000;
            cnt_b_ff <= 10'h000;
            data_ready_strobe_ff <= 1'b0;
            hdr_ff <= 64'h0;
            res_ff <= 128'h0;
        end else if (CLK_EN) begin
            cnt_a_ff <= nxt_cnt_a;
            cnt_b_ff <= nxt_cnt_b;
            data_ready_strobe_ff <= nxt_data_ready_strobe;
            hdr_ff <= nxt_hdr;
            res_ff <= nxt_res;
        end
    end

    // =====================================================
    // outputs
    assign SPI_SDO = tx_ff[15];
    assign SPI_SDO_OE = spi_mode & cs_low;
    assign SYNC_OUT = sync_bit_ff;
    assign CHANNEL_ENABLE = en_ff;
    assign COMMON_MODE_VOLTAGE_OUT = en_ff[0];
    assign CRYSTAL_EXCITE_EN = en_ff[4];
    assign POWER_CFG = power_ff;
    assign IFACE_CFG = iface_ff;
    assign DATA_READY_STROBE = data_ready_strobe_ff;
    assign OUT_HEADER = hdr_ff;
    assign OUT_RESULT = res_ff;

    // =====================================================
    // checks
    default clocking chk_cb @(posedge CORE_CLK); endclocking
    default disable iff (!RESETN);

    chk_bank_pins: assert property (CLK_EN && !pin_ff[6] |=>
        en_ff == ~{{4{$past(pin_ff[5])}}, {4{$past(pin_ff[4])}}})
        else $error("bank standby pins not followed");
    chk_vcm_off: assert property (CLK_EN && spi_mode && standby_ff[0] |=>
        !COMMON_MODE_VOLTAGE_OUT)
        else $error("common-mode output on with channel 0 idle");
    chk_xtal_off: assert property (CLK_EN && spi_mode && standby_ff[4] |=>
        !CRYSTAL_EXCITE_EN)
        else $error("crystal drive on with channel 4 idle");
    chk_idle_zero: assert property ($rose(data_ready_strobe_ff) && !$past(en_ff[0]) |->
        hdr_ff[7:0] == 8'h00 && res_ff[15:0] == 16'h0000)
        else $error("idle channel slot not zero");
    chk_b_quiet: assert property ($past(act_sel_ff) == 8'hff |-> !data_ready_strobe_ff)
        else $error("data ready with all channels in profile b");
    chk_err_code: assert property (CLK_EN && exec && illegal |=> resp_ff == ERR_RESP)
        else $error("illegal command not answered with error code");
    chk_write_echo: assert property (CLK_EN && exec && !illegal && !srst &&
        !shift_ff[RW_BIT] |=> resp_ff == {8'h00, $past(shift_ff[7:0])})
        else $error("write answer malformed");
    chk_msb_first: assert property (CLK_EN && cs_fall |=> tx_ff == $past(resp_ff))
        else $error("answer not loaded at frame start");
    chk_boot_quiet: assert property (boot_ff != 12'h000 |=>
        $stable(resp_ff) && $stable(standby_ff) && $stable(sel_ff))
        else $error("command taken during start-up window");
    chk_soft_reset: assert property (CLK_EN && srst |=>
        resp_ff == ERR_RESP && sel_ff == SEL_RST && prof_a_ff == PROF_RST)
        else $error("software reset incomplete");
endmodule
`default_nettype wire

// *** bench/spi_host_model.sv ***
// Purpose: host model acting as mode 0 master on the converter control port
// Assumes: link clock half period HALF_NS, unrelated to the core clock
// Notes: the link clock stands still low between frames
`default_nettype none
module spi_host_model #(
    parameter int HALF_NS = 200
) (
    output logic SCLK,
    output logic CS_N,
    output logic SDI,
    input wire logic SDO
);
    timeunit 1ns;
    timeprecision 1ps;

    // =====================================================
    // idle levels: clock low, chip select high
    initial begin
        SCLK = 1'b0;
        CS_N = 1'b1;
        SDI = 1'b0;
    end

    // =====================================================
    // one 16-bit frame, msb first; reply is what came back on sdo
    task automatic xfer(input logic [15:0] cmd, output logic [15:0] reply);
        CS_N = 1'b0;
        for (int i = 15; i >= 0; i--) begin
            SDI = cmd[i];
            #(HALF_NS);
            SCLK = 1'b1;
            reply[i] = SDO;
            #(HALF_NS);
            SCLK = 1'b0;
        end
        #(HALF_NS);
        CS_N = 1'b1;
        SDI = ~SDI; // released line must not look like held data
        #(2 * HALF_NS); // chip select gap well above 4 core cycles
    endtask
endmodule
`default_nettype wire

// *** bench/adc_spi_control_channel_modes_test.sv ***
// Purpose: self-checking bench for the converter control port
// Assumes: 20 MHz core clock, mod tick every cycle
// Notes: profiles are shortened to x32/x64 so strobes come quickly
`default_nettype none
module adc_spi_control_channel_modes_test;
    timeunit 1ns;
    timeprecision 1ps;
    import adc_ctrl_pkg::*;

    localparam logic [63:0] RAW_H = 64'h8e8c8a8886848280;
    localparam logic [127:0] RAW_R = 128'h88887777666655554444333322221111;
    logic core_clk, resetn, spi_select, bank_lo, bank_hi;
    logic sclk, cs_n, sdi, sdo, sdo_oe, sync_out, cm_out, xtal_en, dready;
    logic [7:0] ch_en, pwr, ifc;
    logic [63:0] hdr;
    logic [127:0] res;
    logic sdo_line;
    int err_count = 0;
    int checked = 0;

    adc_ctrl_port dut_u (.CORE_CLK(core_clk), .RESETN(resetn), .CLK_EN(1'b1),
        .SPI_SELECT_PIN(spi_select), .BANK_LOW_STANDBY_PIN(bank_lo),
        .BANK_HIGH_STANDBY_PIN(bank_hi), .SPI_SCLK(sclk), .SPI_CS_N(cs_n),
        .SPI_SDI(sdi), .SYNC_IN_PIN(1'b0), .MOD_TICK(1'b1), .RAW_HEADER(RAW_H),
        .RAW_RESULT(RAW_R), .SPI_SDO(sdo), .SPI_SDO_OE(sdo_oe), .SYNC_OUT(sync_out),
        .CHANNEL_ENABLE(ch_en), .COMMON_MODE_VOLTAGE_OUT(cm_out),
        .CRYSTAL_EXCITE_EN(xtal_en), .POWER_CFG(pwr), .IFACE_CFG(ifc),
        .DATA_READY_STROBE(dready), .OUT_HEADER(hdr), .OUT_RESULT(res));

    // a released answer line shows the inverse, so a late enable shows up
    assign sdo_line = sdo_oe ? sdo : ~sdo;

    spi_host_model host_u (.SCLK(sclk), .CS_N(cs_n), .SDI(sdi), .SDO(sdo_line));

    // =====================================================
    // clock and shared tasks
    always #25 core_clk = ~core_clk;

    task automatic check(input string what, input logic [127:0] seen,
                         input logic [127:0] exp);
        checked++;
        if (seen !== exp) begin
            err_count++;
            $display("ERROR %s expected %0h seen %0h", what, exp, seen);
        end
    endtask

    task automatic wrap_up();
        $display("checks %0d errors %0d", checked, err_count);
        if (err_count == 0 && checked > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    // r is the answer to the previous frame
    task automatic acc(input logic [15:0] c, output logic [15:0] r);
        @(posedge core_clk);
        #1;
        host_u.xfer(c, r);
    endtask

    // bounded wait; gap of 300 means no strobe came
    task automatic wait_strobe(output int gap);
        gap = 0;
        do begin
            @(posedge core_clk);
            #1;
            gap++;
        end while (dready !== 1'b1 && gap < 300);
    endtask

    task automatic do_sync();
        logic [15:0] r;
        acc({1'b0, A_SYNC, 8'h00}, r);
        check("sync_lo", sync_out, 1'b0);
        acc({1'b0, A_SYNC, 8'h80}, r);
        check("sync_hi", sync_out, 1'b1);
    endtask

    // =====================================================
    // scenarios
    task automatic t_defaults();
        check("chan_en", ch_en, 8'hff);
        check("power", pwr, 8'h00);
        check("iface", ifc, 8'h13);
        check("sync_rst", sync_out, 1'b1);
        check("cm_out", cm_out, 1'b1);
        check("xtal", xtal_en, 1'b1);
    endtask

    task automatic t_regs();
        logic [15:0] r;
        acc({1'b1, A_PROF_A, 8'h00}, r);
        acc({1'b1, A_PROF_B, 8'h00}, r);
        check("prof_a", r, {1'b1, A_PROF_A, 8'h0d});
        acc({1'b1, A_PROF_SEL, 8'h00}, r);
        check("prof_b", r, {1'b1, A_PROF_B, 8'h0d});
        acc({1'b1, 7'h7f, 8'h00}, r);
        check("sel", r, {1'b1, A_PROF_SEL, 8'h00});
        acc({1'b0, A_STATUS, 8'h55}, r);
        check("bad_rd", r, ERR_RESP);
        acc({1'b0, A_PROF_A, 8'h00}, r); // wideband x32
        check("bad_wr", r, ERR_RESP);
        acc({1'b0, A_PROF_B, 8'h09}, r); // sinc5 x64
        check("wr_ans", r, 16'h0000);
        acc({1'b0, A_PROF_SEL, 8'h80}, r); // channel 7 on profile b
        check("wr_ans_b", r, 16'h0009);
        acc({1'b1, A_STATUS, 8'h00}, r);
        check("wr_ans_c", r, 16'h0080);
        acc({1'b1, A_STATUS, 8'h00}, r);
        check("pending", r, {1'b1, A_STATUS, 8'h01});
        do_sync();
    endtask

    task automatic t_stream();
        logic [15:0] r;
        int n;
        int stale;
        stale = 0;
        acc({1'b0, A_STANDBY, 8'h11}, r);
        check("wr_ans_s", r, 16'h0080);
        check("stby", ch_en, 8'hee);
        check("cm_off", cm_out, 1'b0);
        check("xtal_off", xtal_en, 1'b0);
        wait_strobe(n);
        for (int k = 0; k < 4; k++) begin
            wait_strobe(n);
            check("rate", n, 32);
            check("idle_h", {hdr[39:32], hdr[7:0]}, 16'h0000);
            check("idle_r", {res[79:64], res[15:0]}, 32'h0);
            check("live", {hdr[31:8], res[63:16]}, {RAW_H[31:8], RAW_R[63:16]});
            if (hdr[63:56] === (RAW_H[63:56] | 8'h01) && res[127:112] === 16'h0) begin
                stale++;
            end else begin
                check("ch7", {hdr[63:56], res[127:112]}, {RAW_H[63:56], RAW_R[127:112]});
            end
        end
        check("stale", stale, 2);
    endtask

    task automatic t_all_b();
        logic [15:0] r;
        int n;
        acc({1'b0, A_PROF_SEL, 8'hff}, r);
        do_sync();
        wait_strobe(n);
        check("no_data", n, 300);
    endtask

    task automatic t_pins();
        spi_select = 1'b0;
        for (int p = 0; p < 4; p++) begin
            {bank_hi, bank_lo} = 2'(p);
            repeat (6) @(posedge core_clk);
            #1;
            check("pins", ch_en, {{4{~bank_hi}}, {4{~bank_lo}}});
            check("sdo_off", sdo_oe, 1'b0);
        end
        {bank_hi, bank_lo} = 2'b00;
        spi_select = 1'b1;
        repeat (6) @(posedge core_clk);
    endtask

    // power is changed first so the reset has something to restore
    task automatic t_soft();
        logic [15:0] r;
        acc({1'b0, A_POWER, 8'h5a}, r);
        check("power_wr", pwr, 8'h5a);
        acc({1'b0, A_SYNC, 8'h83}, r);
        check("power_ans", r, 16'h005a);
        acc({1'b0, A_SYNC, 8'h82}, r);
        acc({1'b0, A_STANDBY, 8'hff}, r); // falls in the quiet window
        check("boot_ans", r, ERR_RESP);
        repeat (BOOT_CYC + 10) @(posedge core_clk);
        check("srst_en", ch_en, 8'hff);
        check("srst_pwr", pwr, 8'h00);
        acc({1'b1, A_PROF_SEL, 8'h00}, r);
        check("srst_ans", r, ERR_RESP);
        acc({1'b1, A_PROF_A, 8'h00}, r);
        check("srst_sel", r, {1'b1, A_PROF_SEL, 8'h00});
    endtask

    // =====================================================
    // watchdog: the whole run needs well under 1 ms
    initial begin
        #2000000;
        err_count++;
        $display("ERROR watchdog expired");
        wrap_up();
    end

    // =====================================================
    // main sequence
    initial begin
        core_clk = 1'b0;
        resetn = 1'b0;
        spi_select = 1'b1;
        bank_lo = 1'b0;
        bank_hi = 1'b0;
        repeat (2) @(posedge core_clk);
        #1;
        resetn = 1'b1;
        repeat (BOOT_CYC + 10) @(posedge core_clk);
        t_defaults();
        t_regs();
        t_stream();
        t_all_b();
        t_pins();
        t_soft();
        wrap_up();
    end
endmodule
`default_nettype wire
